// >>> logic/ftid_pkg.sv
// package for the 14-bit instruction decoder: field positions, categories, timing
// assumes a single core clock; every user writes ftid_pkg::name
package ftid_pkg;
   localparam int WORD_W = 14;
   localparam int REG_ADDR_W = 7;
   localparam int LIT8_W = 8;
   localparam int LIT11_W = 11;
   localparam int BIT_SEL_W = 3;
   localparam int OP_BYTE_HI = 13;
   localparam int OP_BYTE_LO = 8;
   localparam int OP_BIT_LO = 10;
   localparam int OP_CTRL_LO = 11;
   localparam int TARGET_BIT = 7;
   localparam int BITSEL_HI = 9;
   localparam int BITSEL_LO = 7;
   localparam int PHASES_PER_CYCLE = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] TOP_BYTE = 2'h0;
   localparam logic [1:0] TOP_BIT = 2'h1;
   localparam logic [1:0] TOP_CTRL = 2'h2;
   localparam logic [2:0] TOP_CALL = 3'h4;
   localparam logic [2:0] TOP_GOTO = 3'h5;
   localparam logic [6:0] REG_LOC_MAX = 7'h7F;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   typedef enum logic [1:0] {FTID_CAT_BYTE, FTID_CAT_BIT, FTID_CAT_LIT, FTID_CAT_CTRL} ftid_cat_e;
endpackage : ftid_pkg

// >>> logic/ftid_phase_gen.sv
// four-phase sequencer: splits each instruction cycle into four oscillator periods
// assumes clk_in is the core oscillator
module ftid_phase_gen
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // phase outputs
   output logic [1:0] phase_out,
   output logic cycle_end_out
);
   logic [1:0] phase;
   logic [1:0] next_phase;

   always_comb
   begin
      next_phase = phase + 2'h1;
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         phase <= 2'h0;
      end
      else
      begin
         phase <= next_phase;
      end
   end

   assign phase_out = phase;
   assign cycle_end_out = (phase == ftid_pkg::PHASE_LAST);
endmodule : ftid_phase_gen

// >>> logic/ftid_decoder.sv
// 14-bit instruction decoder: splits words into fields and paces instruction cycles
// assumes program memory holds instr_in stable for a whole instruction cycle
module ftid_decoder
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // program memory side
   input wire logic [13:0] instr_in,
   // datapath status
   input wire logic test_true_in,
   input wire logic pc_write_in,
   // cycle pacing
   output logic [1:0] phase_out,
   output logic fetch_out,
   output logic nop_cycle_out,
   // decoded fields
   output ftid_pkg::ftid_cat_e category_out,
   output logic [5:0] opcode_out,
   output logic to_register_out,
   output logic [6:0] register_location_out,
   output logic [2:0] position_in_register_out,
   output logic [7:0] immediate8_out,
   output logic [10:0] immediate11_out,
   output logic [1:0] cycle_count_out
);
   logic cycle_end;
   ftid_pkg::ftid_cat_e cat;
   ftid_pkg::ftid_cat_e next_cat;
   logic [5:0] opcode;
   logic [5:0] next_opcode;
   logic to_reg;
   logic next_to_reg;
   logic [6:0] reg_loc;
   logic [6:0] next_reg_loc;
   logic [2:0] bit_pos;
   logic [2:0] next_bit_pos;
   logic [7:0] lit8;
   logic [7:0] next_lit8;
   logic [10:0] lit11;
   logic [10:0] next_lit11;
   logic [1:0] cyc;
   logic [1:0] next_cyc;
   logic nop_pend;
   logic next_nop_pend;
   logic nop_cyc;
   logic next_nop_cyc;
   logic is_ctrl_xfer;

   ftid_phase_gen u_phase
   (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .phase_out(phase_out),
      .cycle_end_out(cycle_end)
   );

   // jumps and calls always change the program counter
   assign is_ctrl_xfer = (instr_in[13:12] == ftid_pkg::TOP_CTRL);

   always_comb
   begin
      next_cat = cat;
      next_opcode = opcode;
      next_to_reg = to_reg;
      next_reg_loc = reg_loc;
      next_bit_pos = bit_pos;
      next_lit8 = lit8;
      next_lit11 = lit11;
      next_cyc = cyc;
      next_nop_pend = nop_pend;
      next_nop_cyc = nop_cyc;
      if (cycle_end)
      begin
         if (nop_pend)
         begin
            // second cycle executes as a no-op; the fetched word is not decoded
            next_nop_cyc = 1'b1;
            next_nop_pend = 1'b0;
         end
         else
         begin
            next_nop_cyc = 1'b0;
            // category from upper bits before any operand is taken
            case (instr_in[13:12])
               ftid_pkg::TOP_BYTE:
               begin
                  next_cat = ftid_pkg::FTID_CAT_BYTE;
                  next_opcode = instr_in[13:8];
               end
               ftid_pkg::TOP_BIT:
               begin
                  next_cat = ftid_pkg::FTID_CAT_BIT;
                  next_opcode = {2'h0, instr_in[13:10]};
               end
               ftid_pkg::TOP_CTRL:
               begin
                  next_cat = ftid_pkg::FTID_CAT_CTRL;
                  next_opcode = {3'h0, instr_in[13:11]};
               end
               default:
               begin
                  next_cat = ftid_pkg::FTID_CAT_LIT;
                  next_opcode = instr_in[13:8];
               end
            endcase
            // operand fields sliced unconditionally; unused fields are don't-care
            next_to_reg = instr_in[7];
            next_reg_loc = instr_in[6:0];
            next_bit_pos = instr_in[9:7];
            next_lit8 = instr_in[7:0];
            next_lit11 = instr_in[10:0];
            next_cyc = is_ctrl_xfer ? ftid_pkg::CYC_TWO : ftid_pkg::CYC_ONE;
            // a jump or call always reloads the program counter, so its second cycle is a no-op
            next_nop_pend = is_ctrl_xfer;
         end
      end
      // a taken skip or program counter write in phases 0 to 2 of execution costs one no-op cycle; one at the phase 3 fetch edge is dropped
      if ((test_true_in || pc_write_in) && !nop_cyc && !cycle_end)
      begin
         next_nop_pend = 1'b1;
         next_cyc = ftid_pkg::CYC_TWO;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         cat <= ftid_pkg::FTID_CAT_BYTE;
         opcode <= 6'h00;
         to_reg <= 1'b0;
         reg_loc <= 7'h00;
         bit_pos <= 3'h0;
         lit8 <= 8'h00;
         lit11 <= 11'h000;
         cyc <= ftid_pkg::CYC_ONE;
         nop_pend <= 1'b0;
         nop_cyc <= 1'b0;
      end
      else
      begin
         cat <= next_cat;
         opcode <= next_opcode;
         to_reg <= next_to_reg;
         reg_loc <= next_reg_loc;
         bit_pos <= next_bit_pos;
         lit8 <= next_lit8;
         lit11 <= next_lit11;
         cyc <= next_cyc;
         nop_pend <= next_nop_pend;
         nop_cyc <= next_nop_cyc;
      end
   end

   // ignored positions are simply never looked at
   assign category_out = cat;
   assign opcode_out = opcode;
   assign to_register_out = to_reg;
   assign register_location_out = reg_loc;
   assign position_in_register_out = bit_pos;
   assign immediate8_out = lit8;
   assign immediate11_out = lit11;
   assign cycle_count_out = cyc;
   assign nop_cycle_out = nop_cyc;
   assign fetch_out = cycle_end;

   property p_phase_wrap;
      @(posedge clk_in) disable iff (!rstn_in)
      fetch_out |=> !fetch_out [*3] ##1 fetch_out;
   endproperty
   a_phase_wrap: assert property (p_phase_wrap) else $error("cycle not four periods");

   property p_fields_hold;
      @(posedge clk_in) disable iff (!rstn_in)
      !fetch_out |=> $stable(opcode_out) && $stable(category_out);
   endproperty
   a_fields_hold: assert property (p_fields_hold) else $error("fields moved mid-cycle");

   property p_target;
      @(posedge clk_in) disable iff (!rstn_in)
      (fetch_out && !nop_pend) |=> to_register_out == $past(instr_in[7]);
   endproperty
   a_target: assert property (p_target) else $error("target bit wrong");

   property p_byte;
      @(posedge clk_in) disable iff (!rstn_in)
      (fetch_out && !nop_pend && instr_in[13:12] == 2'h0)
      |=> opcode_out == $past(instr_in[13:8]) && register_location_out == $past(instr_in[6:0]);
   endproperty
   a_byte: assert property (p_byte) else $error("byte decode wrong");

   property p_bit;
      @(posedge clk_in) disable iff (!rstn_in)
      (fetch_out && !nop_pend && instr_in[13:12] == 2'h1)
      |=> position_in_register_out == $past(instr_in[9:7])
      && category_out == ftid_pkg::FTID_CAT_BIT;
   endproperty
   a_bit: assert property (p_bit) else $error("bit decode wrong");

   property p_lit;
      @(posedge clk_in) disable iff (!rstn_in)
      (fetch_out && !nop_pend && instr_in[13:12] == 2'h3)
      |=> immediate8_out == $past(instr_in[7:0]);
   endproperty
   a_lit: assert property (p_lit) else $error("literal decode wrong");

   property p_ctrl;
      @(posedge clk_in) disable iff (!rstn_in)
      (fetch_out && !nop_pend && instr_in[13:12] == 2'h2)
      |=> immediate11_out == $past(instr_in[10:0]) && cycle_count_out == 2'h2;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control decode wrong");

   property p_nop;
      @(posedge clk_in) disable iff (!rstn_in)
      (fetch_out && nop_pend) |=> nop_cycle_out [*4] ##1 !nop_cycle_out;
   endproperty
   a_nop: assert property (p_nop) else $error("no-op cycle length wrong");

endmodule : ftid_decoder

// >>> tb/ftid_mem_model.sv
// program memory stand-in for the decoder
// assumes phase_in comes from the decoder
module ftid_mem_model
(
   // clock and phase
   input wire logic clk_in,
   input wire logic [1:0] phase_in,
   // word from the bench
   input wire logic [13:0] word_in,
   // word to the decoder
   output logic [13:0] instr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // load in phase 0 so the word is settled long before the fetch edge
   always_ff @(posedge clk_in)
   begin
      if (phase_in == 2'h0)
      begin
         instr_out <= word_in;
      end
   end
endmodule : ftid_mem_model

// >>> tb/tb_top.sv
// self-checking bench for the instruction decoder
// assumes the package, decoder and memory stand-in compile first
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [13:0] word_in = 14'h0000;
   logic test_true_in = 1'b0;
   logic pc_write_in = 1'b0;
   logic [13:0] instr;
   logic [1:0] phase_out, cycle_count_out;
   logic fetch_out, nop_cycle_out, to_register_out;
   ftid_pkg::ftid_cat_e category_out;
   logic [5:0] opcode_out;
   logic [6:0] register_location_out;
   logic [2:0] position_in_register_out;
   logic [7:0] immediate8_out;
   logic [10:0] immediate11_out;
   int bad_count = 0;
   int samples_checked = 0;
   ftid_pkg::ftid_cat_e cat_map [4] = '{ftid_pkg::FTID_CAT_BYTE, ftid_pkg::FTID_CAT_BIT,
      ftid_pkg::FTID_CAT_CTRL, ftid_pkg::FTID_CAT_LIT};
   // bits 15:14 of each entry carry the test and program counter pulses
   logic [15:0] plan [9] = '{16'h077F, 16'h0C80, 16'h1BFF, 16'h9C05, 16'h3EA5,
      16'h34A5, 16'h2ABC, 16'h4A23, 16'hB0FF};

   ftid_mem_model ftid_mem_model_i (.clk_in(clk_in), .phase_in(phase_out),
      .word_in(word_in), .instr_out(instr));
   ftid_decoder ftid_decoder_i (.clk_in(clk_in), .rstn_in(rstn_in), .instr_in(instr),
      .test_true_in(test_true_in), .pc_write_in(pc_write_in), .phase_out(phase_out),
      .fetch_out(fetch_out), .nop_cycle_out(nop_cycle_out), .category_out(category_out),
      .opcode_out(opcode_out), .to_register_out(to_register_out),
      .register_location_out(register_location_out),
      .position_in_register_out(position_in_register_out),
      .immediate8_out(immediate8_out), .immediate11_out(immediate11_out),
      .cycle_count_out(cycle_count_out));

   initial
   begin
      forever #10 clk_in = ~clk_in;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   task automatic check_fields(input logic [13:0] w);
      logic [5:0] op;
      op = (w[13:12] == 2'h1) ? {2'h0, w[13:10]} : w[13:8];
      op = (w[13:12] == 2'h2) ? {3'h0, w[13:11]} : op;
      check(category_out, cat_map[w[13:12]]);
      check(opcode_out, op);
      check(to_register_out, w[7]);
      check(register_location_out, w[6:0]);
      check(position_in_register_out, w[9:7]);
      check(immediate8_out, w[7:0]);
      check(immediate11_out, w[10:0]);
   endtask : check_fields

   // entered and left at a falling edge of phase 0
   task automatic step(input logic [13:0] w, input logic t, input logic p);
      logic two;
      two = t | p | (w[13:12] == 2'h2);
      word_in = w;
      repeat (4) @(negedge clk_in);
      // a changed word must be refused on the edge before a no-op
      word_in = two ? ~w : w;
      test_true_in = t;
      pc_write_in = p;
      check_fields(w);
      check(nop_cycle_out, 16'h0);
      @(negedge clk_in);
      test_true_in = 1'b0;
      pc_write_in = 1'b0;
      repeat (2) @(negedge clk_in);
      check(cycle_count_out, two ? 16'h2 : 16'h1);
      @(negedge clk_in);
      if (two)
      begin
         word_in = 14'h0000;
         check(nop_cycle_out, 16'h1);
         check_fields(w);
         repeat (3) @(negedge clk_in);
         check(nop_cycle_out, 16'h1);
         @(negedge clk_in);
         check(nop_cycle_out, 16'h0);
      end
   endtask : step

   initial
   begin
      repeat (3) @(negedge clk_in);
      check(phase_out, 16'h0);
      check(nop_cycle_out, 16'h0);
      check(category_out, ftid_pkg::FTID_CAT_BYTE);
      check(cycle_count_out, 16'h1);
      repeat (3) @(negedge clk_in);
      rstn_in = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         check(phase_out, i[1:0]);
         check(fetch_out, {15'h0, i[1:0] == 2'h3});
         @(negedge clk_in);
      end
      foreach (plan[i])
      begin
         step(plan[i][13:0], plan[i][15], plan[i][14]);
      end
      complete_run();
   end

   initial
   begin
      #100us;
      bad_count++;
      complete_run();
   end
endmodule : tb_top
